// >>> hdl/acs_cs_seq.v
// Current-sense converter sequencer: start, timing, result and ready pin.
// Assumes the decimation filter output is on the core clock and valid
// whenever a conversion period ends.
`timescale 1ns/100ps
`include "acs_defs.vh"

module acs_cs_seq
(
  input  wire        clock,
  input  wire        resetn,
  input  wire        main_go_pulse,
  input  wire [1:0]  main_run_mode,
  input  wire        main_adc_running,
  input  wire [1:0]  current_decimation_ratio,
  input  wire [23:0] cs_filter_data,
  input  wire        current_result_high_read,
  input  wire        cs_ready_pin_enable,
  output reg  [23:0] current_result_r,
  output reg         cs_running_r,
  output reg         cs_conv_done_r,
  output reg         gpio1_out_r,
  output reg         gpio1_oe_r
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_FIRST  = 2'h2;
  localparam [1:0] ST_NEXT   = 2'h3;

  // Timing counts at the width of the period counter
  localparam [15:0] CS_SETTLE = `ACS_CS_SETTLE_CYC;
  localparam [15:0] CS_CONV0  = `ACS_CS_CONV0_CYC;
  localparam [15:0] CS_CONV1  = `ACS_CS_CONV1_CYC;
  localparam [15:0] CS_CONV2  = `ACS_CS_CONV2_CYC;
  localparam [15:0] CS_CONV3  = `ACS_CS_CONV3_CYC;
  localparam [15:0] CS_DIV    = `ACS_CS_DIVIDER;

  reg [1:0]  state_r;
  reg [15:0] cnt_r;
  reg [1:0]  dr_r;

  // Full conversion period for a decimation ratio
  function [15:0] conv_full;
    input [1:0] dr;
    begin
      if (dr == 2'h0)
        conv_full = CS_CONV0;
      else if (dr == 2'h1)
        conv_full = CS_CONV1;
      else if (dr == 2'h2)
        conv_full = CS_CONV2;
      else
        conv_full = CS_CONV3;
    end
  endfunction

  // ************************************************************
  // Conversion timing
  // ************************************************************
  // Settle, one full period, then periods of one third each
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r          <= ST_IDLE;
      cnt_r            <= 16'h0000;
      dr_r             <= 2'h0;
      cs_running_r     <= 1'b0;
      cs_conv_done_r   <= 1'b0;
      current_result_r <= 24'h000000;
    end
    else
    begin
      cs_conv_done_r <= 1'b0;
      if (main_go_pulse && (main_run_mode != 2'h0))
      begin
        state_r      <= ST_SETTLE;
        cnt_r        <= CS_SETTLE - 16'h0001;
        dr_r         <= current_decimation_ratio;
        cs_running_r <= 1'b1;
      end
      else if ((main_go_pulse && (main_run_mode == 2'h0)) || !main_adc_running)
      begin
        state_r      <= ST_IDLE;
        cs_running_r <= 1'b0;
      end
      else if (state_r != ST_IDLE)
      begin
        if (cnt_r != 16'h0000)
          cnt_r <= cnt_r - 16'h0001;
        else if (state_r == ST_SETTLE)
        begin
          state_r <= ST_FIRST;
          cnt_r   <= conv_full(dr_r) - 16'h0001;
        end
        else
        begin
          state_r          <= ST_NEXT;
          cnt_r            <= (conv_full(dr_r) / CS_DIV) - 16'h0001;
          current_result_r <= cs_filter_data;
          cs_conv_done_r   <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Ready pin
  // ************************************************************
  // Low on each result, high again once the high byte is read
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      gpio1_out_r <= 1'b1;
      gpio1_oe_r  <= 1'b0;
    end
    else
    begin
      gpio1_oe_r <= cs_ready_pin_enable;
      if (!cs_ready_pin_enable)
        gpio1_out_r <= 1'b1;
      else if (cs_conv_done_r)
        gpio1_out_r <= 1'b0;
      else if (current_result_high_read)
        gpio1_out_r <= 1'b1;
    end
  end

endmodule // acs_cs_seq

// >>> hdl/acs_defs.vh
// Shared constants for the auxiliary and current-sense ADC sequencer.
// Assumes a 100 MHz core clock; times are given in microseconds.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ************************************************************
// Clock
// ************************************************************
`define ACS_CLK_MHZ          100

// ************************************************************
// Auxiliary run modes
// ************************************************************
`define ACS_MODE_STOP        2'h0
`define ACS_MODE_SINGLE      2'h1
`define ACS_MODE_CONT        2'h2
`define ACS_MODE_EIGHT       2'h3
`define ACS_EIGHT_CYCLES     4'h8

// ************************************************************
// Round-robin slot map
// ************************************************************
`define ACS_SLOT_DIETEMP     4'h0
`define ACS_SLOT_CELL        4'h5
`define ACS_SLOT_GPIO        4'h6
`define ACS_SLOT_LAST        4'hE
`define ACS_GPIO_COUNT       4'h8
`define ACS_MAX_CELLS        4'h6

// ************************************************************
// Cell and GPIO selection codes
// ************************************************************
`define ACS_CELL_LOOP        5'h00
`define ACS_CELL_SENSE       5'h01
`define ACS_CELL_LOCK_FIRST  5'h02
`define ACS_CELL_LOCK_LAST   5'h07
`define ACS_GPIO_LOOP        4'h0
`define ACS_GPIO_LOCK_LAST   4'h8
`define ACS_RESULT_DEFAULT   16'h8000

// ************************************************************
// Filter settling times
// ************************************************************
`define ACS_SETTLE0_US       4300
`define ACS_SETTLE1_US       2300
`define ACS_SETTLE2_US       1300

// ************************************************************
// Current-sense converter timing
// ************************************************************
`define ACS_CS_SETTLE_US     10
`define ACS_CS_CONV0_US      12
`define ACS_CS_CONV1_US      24
`define ACS_CS_CONV2_US      36
`define ACS_CS_CONV3_US      39
`define ACS_CS_SETTLE_CYC    (`ACS_CS_SETTLE_US * `ACS_CLK_MHZ)
`define ACS_CS_CONV0_CYC     (`ACS_CS_CONV0_US * `ACS_CLK_MHZ)
`define ACS_CS_CONV1_CYC     (`ACS_CS_CONV1_US * `ACS_CLK_MHZ)
`define ACS_CS_CONV2_CYC     (`ACS_CS_CONV2_US * `ACS_CLK_MHZ)
`define ACS_CS_CONV3_CYC     (`ACS_CS_CONV3_US * `ACS_CLK_MHZ)
`define ACS_CS_DIVIDER       3

`endif

// >>> hdl/acs_top.v
// Auxiliary ADC round-robin sequencer with the current-sense sequencer.
// Assumes control inputs come from register logic on the same clock and
// the auxiliary converter answers each start with a one-cycle done.
`timescale 1ns/100ps
`include "acs_defs.vh"

module acs_top
#(
  parameter [19:0] SETTLE0_CYC = `ACS_SETTLE0_US * `ACS_CLK_MHZ,
  parameter [19:0] SETTLE1_CYC = `ACS_SETTLE1_US * `ACS_CLK_MHZ,
  parameter [19:0] SETTLE2_CYC = `ACS_SETTLE2_US * `ACS_CLK_MHZ
)
(
  input  wire        clock,
  input  wire        resetn,
  input  wire        aux_go_write,
  input  wire [1:0]  aux_run_mode_field,
  input  wire [4:0]  aux_cell_channel_select,
  input  wire [1:0]  aux_filter_settle_select,
  input  wire [3:0]  aux_gpio_channel_select,
  input  wire [3:0]  active_cell_count,
  input  wire [7:0]  gpio_function_config,
  input  wire        sleep_mode,
  input  wire        main_target_strobe,
  input  wire        main_go_pulse,
  input  wire [1:0]  main_run_mode,
  input  wire        main_adc_running,
  input  wire        aux_conv_done,
  input  wire [15:0] aux_conv_data,
  input  wire [1:0]  current_decimation_ratio,
  input  wire [23:0] cs_filter_data,
  input  wire        current_result_high_read,
  input  wire        cs_ready_pin_enable,
  output reg         aux_conv_start_r,
  output reg  [3:0]  aux_conv_slot_r,
  output reg  [2:0]  aux_conv_cell_r,
  output reg  [2:0]  aux_conv_gpio_r,
  output reg         aux_running_flag_r,
  output reg         aux_misc_ready_flag_r,
  output reg         aux_cell_ready_flag_r,
  output reg         aux_gpio_ready_flag_r,
  output reg  [15:0] aux_cell_result_r,
  output reg  [15:0] aux_gpio_result_r,
  output reg         aux_go_readback_r,
  output wire [23:0] current_result,
  output wire        cs_running,
  output wire        cs_conv_done,
  output wire        gpio1_out,
  output wire        gpio1_oe
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_LAUNCH = 2'h1;
  localparam [1:0] ST_WAIT   = 2'h2;

  // ************************************************************
  // Captured configuration and sequencer state
  // ************************************************************
  reg [1:0]  state_r;
  reg [1:0]  mode_cap_r;
  reg [4:0]  cell_sel_cap_r;
  reg [1:0]  settle_sel_cap_r;
  reg [3:0]  gpio_sel_cap_r;
  reg [3:0]  ncell_cap_r;
  reg [7:0]  gpio_act_cap_r;
  reg [3:0]  slot_r;
  reg [3:0]  cycle_cnt_r;
  reg [3:0]  gpio_visit_r;
  reg [2:0]  cell_ch_r;
  reg [19:0] settle_cnt_r;
  reg        settle_reload_r;

  wire       settled;
  wire [2:0] gpio_index;
  wire [3:0] ncell_eff;
  wire       cell_locked;
  wire       cell_lock_ok;
  wire       gpio_locked;

  // Lock to a single cell channel (codes 2..7 map to cells 1..6)
  function is_cell_lock;
    input [4:0] sel;
    begin
      is_cell_lock = (sel >= `ACS_CELL_LOCK_FIRST) && (sel <= `ACS_CELL_LOCK_LAST);
    end
  endfunction

  // Cell mux channel for a selection; 0 stands for the sense input
  function [2:0] cell_of_sel;
    input [4:0] sel;
    begin
      if (is_cell_lock(sel))
        cell_of_sel = sel[2:0] - 3'h1;
      else if (sel == `ACS_CELL_SENSE)
        cell_of_sel = 3'h0;
      else
        cell_of_sel = 3'h1;
    end
  endfunction

  // Loop order of the GPIO slot: odd-numbered pins first
  function [2:0] gpio_order;
    input [2:0] visit;
    begin
      gpio_order = {visit[1:0], visit[2]};
    end
  endfunction

  // Settling count for the captured settle selection
  function [19:0] settle_of;
    input [1:0] s;
    begin
      if (s == 2'h0)
        settle_of = SETTLE0_CYC;
      else if (s == 2'h1)
        settle_of = SETTLE1_CYC;
      else
        settle_of = SETTLE2_CYC;
    end
  endfunction

  // Decodes of the captured settings
  assign ncell_eff    = (ncell_cap_r == 4'h0) ? 4'h1 :
                        ((ncell_cap_r > `ACS_MAX_CELLS) ? `ACS_MAX_CELLS : ncell_cap_r);
  assign cell_locked  = is_cell_lock(cell_sel_cap_r) || (cell_sel_cap_r == `ACS_CELL_SENSE);
  assign cell_lock_ok = (cell_sel_cap_r == `ACS_CELL_SENSE) ||
                        (is_cell_lock(cell_sel_cap_r) &&
                         ({1'b0, cell_of_sel(cell_sel_cap_r)} <= ncell_eff));
  assign gpio_locked  = (gpio_sel_cap_r != `ACS_GPIO_LOOP) &&
                        (gpio_sel_cap_r <= `ACS_GPIO_LOCK_LAST);
  assign gpio_index   = gpio_locked ? (gpio_sel_cap_r[2:0] - 3'h1) :
                        gpio_order(gpio_visit_r[2:0]);
  assign settled      = (settle_cnt_r == 20'h00000);

  // ************************************************************
  // Filter settling timer
  // ************************************************************
  // Counts the dwell of the cell mux; frozen while asleep
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      settle_cnt_r <= 20'h00000;
    else if (settle_reload_r)
      settle_cnt_r <= settle_of(settle_sel_cap_r);
    else if (aux_running_flag_r && !sleep_mode && !settled)
      settle_cnt_r <= settle_cnt_r - 20'h00001;
  end

  // ************************************************************
  // Round-robin sequencer
  // ************************************************************
  // Go capture, slot walk, cycle counting and result handling
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r               <= ST_IDLE;
      mode_cap_r            <= `ACS_MODE_STOP;
      cell_sel_cap_r        <= `ACS_CELL_LOOP;
      settle_sel_cap_r      <= 2'h0;
      gpio_sel_cap_r        <= `ACS_GPIO_LOOP;
      ncell_cap_r           <= 4'h0;
      gpio_act_cap_r        <= 8'h00;
      slot_r                <= `ACS_SLOT_DIETEMP;
      cycle_cnt_r           <= 4'h0;
      gpio_visit_r          <= 4'h0;
      cell_ch_r             <= 3'h1;
      settle_reload_r       <= 1'b0;
      aux_conv_start_r      <= 1'b0;
      aux_conv_slot_r       <= 4'h0;
      aux_conv_cell_r       <= 3'h0;
      aux_conv_gpio_r       <= 3'h0;
      aux_running_flag_r    <= 1'b0;
      aux_misc_ready_flag_r <= 1'b0;
      aux_cell_ready_flag_r <= 1'b0;
      aux_gpio_ready_flag_r <= 1'b0;
      aux_cell_result_r     <= `ACS_RESULT_DEFAULT;
      aux_gpio_result_r     <= `ACS_RESULT_DEFAULT;
      aux_go_readback_r     <= 1'b0;
    end
    else
    begin
      aux_conv_start_r  <= 1'b0;
      settle_reload_r   <= 1'b0;
      aux_go_readback_r <= 1'b0;
      if (aux_go_write)
      begin
        // Settings are sampled here only
        mode_cap_r            <= aux_run_mode_field;
        cell_sel_cap_r        <= aux_cell_channel_select;
        settle_sel_cap_r      <= aux_filter_settle_select;
        gpio_sel_cap_r        <= aux_gpio_channel_select;
        ncell_cap_r           <= active_cell_count;
        gpio_act_cap_r        <= gpio_function_config;
        slot_r                <= `ACS_SLOT_DIETEMP;
        cycle_cnt_r           <= 4'h0;
        gpio_visit_r          <= 4'h0;
        cell_ch_r             <= cell_of_sel(aux_cell_channel_select);
        settle_reload_r       <= 1'b1;
        aux_misc_ready_flag_r <= 1'b0;
        aux_cell_ready_flag_r <= 1'b0;
        aux_gpio_ready_flag_r <= 1'b0;
        if (aux_run_mode_field == `ACS_MODE_STOP)
        begin
          state_r            <= ST_IDLE;
          aux_running_flag_r <= 1'b0;
        end
        else
        begin
          state_r            <= ST_LAUNCH;
          aux_running_flag_r <= 1'b1;
        end
      end
      else
      begin
        case (state_r)
          ST_LAUNCH:
          begin
            // Hold while asleep; cell slot waits for the main target while the main ADC runs
            if (!sleep_mode && ((slot_r != `ACS_SLOT_CELL) || !main_adc_running ||
                main_target_strobe))
            begin
              aux_conv_start_r <= 1'b1;
              aux_conv_slot_r  <= slot_r;
              aux_conv_cell_r  <= cell_ch_r;
              aux_conv_gpio_r  <= gpio_index;
              state_r          <= ST_WAIT;
            end
          end
          ST_WAIT:
          begin
            if (aux_conv_done)
            begin
              if (slot_r == `ACS_SLOT_CELL)
              begin
                // Results before settling are discarded
                if (settled && cell_locked)
                begin
                  if (cell_lock_ok)
                    aux_cell_result_r <= aux_conv_data;
                  aux_cell_ready_flag_r <= 1'b1;
                end
                else if (settled)
                begin
                  // Loop walks cells 1 to highest active, then wraps
                  if ({1'b0, cell_ch_r} >= ncell_eff)
                  begin
                    cell_ch_r             <= 3'h1;
                    aux_cell_ready_flag_r <= 1'b1;
                  end
                  else
                    cell_ch_r <= cell_ch_r + 3'h1;
                  settle_reload_r <= 1'b1;
                end
              end
              if (slot_r == `ACS_SLOT_GPIO)
              begin
                // Inactive GPIO slots are visited but not reported
                if (gpio_locked && gpio_act_cap_r[gpio_index])
                  aux_gpio_result_r <= aux_conv_data;
                gpio_visit_r <= gpio_visit_r + 4'h1;
                if (gpio_visit_r == (`ACS_GPIO_COUNT - 4'h1))
                  aux_gpio_ready_flag_r <= 1'b1;
              end
              // End of a cycle decides whether to run on
              if (slot_r == `ACS_SLOT_LAST)
              begin
                slot_r                <= `ACS_SLOT_DIETEMP;
                cycle_cnt_r           <= cycle_cnt_r + 4'h1;
                aux_misc_ready_flag_r <= 1'b1;
                if ((mode_cap_r == `ACS_MODE_SINGLE) ||
                    ((mode_cap_r == `ACS_MODE_EIGHT) &&
                     (cycle_cnt_r == (`ACS_EIGHT_CYCLES - 4'h1))))
                begin
                  state_r            <= ST_IDLE;
                  aux_running_flag_r <= 1'b0;
                end
                else
                  state_r <= ST_LAUNCH;
              end
              else
              begin
                // Next slot of the same cycle
                slot_r  <= slot_r + 4'h1;
                state_r <= ST_LAUNCH;
              end
            end
          end
          // Idle waits for the next go command
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Current-sense converter
  // ************************************************************
  // Input range of plus/minus 125 mV is handled by the analog front end
  acs_cs_seq u_cs_seq
  (
    .clock                    (clock),
    .resetn                   (resetn),
    .main_go_pulse            (main_go_pulse),
    .main_run_mode            (main_run_mode),
    .main_adc_running         (main_adc_running),
    .current_decimation_ratio (current_decimation_ratio),
    .cs_filter_data           (cs_filter_data),
    .current_result_high_read (current_result_high_read),
    .cs_ready_pin_enable      (cs_ready_pin_enable),
    .current_result_r         (current_result),
    .cs_running_r             (cs_running),
    .cs_conv_done_r           (cs_conv_done),
    .gpio1_out_r              (gpio1_out),
    .gpio1_oe_r               (gpio1_oe)
  );

endmodule // acs_top

// >>> tb/acs_conv_model.sv
// Behavioural auxiliary converter and main ADC target strobe source.
// Assumes one-cycle start pulses and a slot number held with each start.
`timescale 1ns/100ps

module acs_conv_model
(
  input  wire        clock,
  input  wire        resetn,
  input  wire        start,
  input  wire [3:0]  slot,
  input  wire        main_running,
  output reg         done,
  output reg  [15:0] data,
  output reg         target
);
  reg [1:0] pipe_r;
  reg [2:0] tgt_r;

  // Answer each start three cycles later; data is junk outside the done cycle
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pipe_r <= 2'h0;
      done   <= 1'b0;
      data   <= 16'h0000;
      tgt_r  <= 3'h0;
      target <= 1'b0;
    end
    else
    begin
      pipe_r <= {pipe_r[0], start};
      done   <= pipe_r[1];
      data   <= pipe_r[1] ? {12'hA00, slot} : ~data;
      tgt_r  <= tgt_r + 3'h1;
      target <= main_running && (tgt_r == 3'h7);
    end
  end
endmodule // acs_conv_model

// >>> tb/acs_top_sva.sv
// Checker for the sequencer's ports.
// Assumes a single clock domain with asynchronous active-low reset.
`timescale 1ns/100ps

module acs_top_chk
#(
  parameter [19:0] SETTLE0_CYC = 20'h14,
  parameter [19:0] SETTLE1_CYC = 20'h0F,
  parameter [19:0] SETTLE2_CYC = 20'h0A
)
(
  input wire       clock,
  input wire       resetn,
  input wire       aux_go_write,
  input wire [1:0] aux_run_mode_field,
  input wire       sleep_mode,
  input wire       main_target_strobe,
  input wire       main_adc_running,
  input wire       current_result_high_read,
  input wire       cs_ready_pin_enable,
  input wire       aux_conv_start_r,
  input wire [3:0] aux_conv_slot_r,
  input wire       aux_running_flag_r,
  input wire       aux_go_readback_r,
  input wire       cs_running,
  input wire       cs_conv_done,
  input wire       gpio1_out,
  input wire       gpio1_oe
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_go_reads_zero: assert property (!aux_go_readback_r)
    else $error("go bit read back as one");
  a_go_sets_run: assert property (aux_go_write |=>
    aux_running_flag_r == ($past(aux_run_mode_field) != 2'h0)) else $error("run flag wrong");
  a_first_slot: assert property (aux_go_write && aux_run_mode_field != 2'h0 ##1
    !aux_go_write && !sleep_mode |=> aux_conv_start_r && aux_conv_slot_r == 4'h0)
    else $error("first slot not die temperature");
  a_sleep_freeze: assert property (sleep_mode |=> !aux_conv_start_r)
    else $error("start during sleep");
  a_stop_quiet: assert property (aux_go_write && aux_run_mode_field == 2'h0
    |=> !aux_conv_start_r [*8]) else $error("start after stop");
  a_idle_quiet: assert property (!aux_running_flag_r && !$past(aux_running_flag_r)
    |-> !aux_conv_start_r) else $error("start while not running");
  a_cell_sync: assert property (aux_conv_start_r && aux_conv_slot_r == 4'h5
    && $past(main_adc_running) |-> $past(main_target_strobe)) else $error("cell slot skew");
  a_cs_pulse: assert property (cs_conv_done |=> !cs_conv_done)
    else $error("done pulse too long");
  a_cs_halt: assert property (!main_adc_running |=> !cs_running)
    else $error("current converter kept running");
  a_pin_fall: assert property (cs_conv_done && cs_ready_pin_enable |=> !gpio1_out)
    else $error("ready pin did not fall");
  a_pin_rise: assert property (current_result_high_read && !cs_conv_done
    && !$past(cs_conv_done) |=> gpio1_out) else $error("ready pin did not rise");
  a_oe_follow: assert property ($changed(cs_ready_pin_enable) |=>
    gpio1_oe == $past(cs_ready_pin_enable)) else $error("pin enable not followed");

  c_eight: cover property (aux_go_write && aux_run_mode_field == 2'h3);
  c_sleep: cover property (sleep_mode && aux_running_flag_r);
  c_cs_done: cover property (cs_conv_done && cs_ready_pin_enable);
endmodule // acs_top_chk

bind acs_top acs_top_chk #(.SETTLE0_CYC(SETTLE0_CYC), .SETTLE1_CYC(SETTLE1_CYC),
  .SETTLE2_CYC(SETTLE2_CYC)) acs_top_chk_i (.clock, .resetn, .aux_go_write,
  .aux_run_mode_field, .sleep_mode, .main_target_strobe, .main_adc_running,
  .current_result_high_read, .cs_ready_pin_enable, .aux_conv_start_r, .aux_conv_slot_r,
  .aux_running_flag_r, .aux_go_readback_r, .cs_running, .cs_conv_done, .gpio1_out,
  .gpio1_oe);

// >>> tb/acs_top_tb.sv
// Self-checking bench for the sequencer, with a converter model.
// Assumes settle counts shortened by parameter; current timing from header.
`timescale 1ns/100ps
`include "acs_defs.vh"
`define CHK(g, e, m) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
  fail_count = fail_count + 1; $display("[FAIL] %0t %s", $time, m); end end

module acs_top_tb;
  reg clock = 1'b0, resetn = 1'b0, aux_go_write = 1'b0, sleep_mode = 1'b0;
  reg [1:0] aux_run_mode_field = 2'h0, aux_filter_settle_select = 2'h2;
  reg [4:0] aux_cell_channel_select = 5'h00;
  reg [3:0] aux_gpio_channel_select = 4'h0;
  reg [7:0] gpio_function_config = 8'hFF;
  reg main_go_pulse = 1'b0, main_adc_running = 1'b0, rd_hi = 1'b0, pin_en = 1'b0;
  reg [1:0] main_run_mode = 2'h0, dr = 2'h0;
  wire strobe, conv_done, start, cs_run, cs_done, pin, pin_oe, run, misc_rdy, cell_rdy, gpio_rdy;
  wire [15:0] conv_data, cell_res, gpio_res;
  wire [3:0] slot;
  wire [2:0] gsel, csel;
  wire [23:0] cur;
  wire readback;
  integer fail_count = 0, n_checks = 0, n_starts = 0, cs_n = 0, cyc = 0, i, k, t0, p;
  integer cs_t0 = 0, cs_t1 = 0;
  reg [23:0] gpio_seq = 24'h000000;
  reg [2:0] cell_last = 3'h0;

  acs_top #(.SETTLE0_CYC(20'h14), .SETTLE1_CYC(20'h0F), .SETTLE2_CYC(20'h0A)) acs_top_i (
    .clock(clock), .resetn(resetn), .aux_go_write(aux_go_write),
    .aux_run_mode_field(aux_run_mode_field), .aux_cell_channel_select(aux_cell_channel_select),
    .aux_filter_settle_select(aux_filter_settle_select),
    .aux_gpio_channel_select(aux_gpio_channel_select), .active_cell_count(4'h6),
    .gpio_function_config(gpio_function_config), .sleep_mode(sleep_mode),
    .main_target_strobe(strobe), .main_go_pulse(main_go_pulse), .main_run_mode(main_run_mode),
    .main_adc_running(main_adc_running), .aux_conv_done(conv_done), .aux_conv_data(conv_data),
    .current_decimation_ratio(dr), .cs_filter_data(24'hF12345),
    .current_result_high_read(rd_hi), .cs_ready_pin_enable(pin_en),
    .aux_conv_start_r(start), .aux_conv_slot_r(slot), .aux_conv_cell_r(csel),
    .aux_conv_gpio_r(gsel), .aux_running_flag_r(run), .aux_misc_ready_flag_r(misc_rdy),
    .aux_cell_ready_flag_r(cell_rdy), .aux_gpio_ready_flag_r(gpio_rdy),
    .aux_cell_result_r(cell_res), .aux_gpio_result_r(gpio_res), .aux_go_readback_r(readback),
    .current_result(cur), .cs_running(cs_run), .cs_conv_done(cs_done), .gpio1_out(pin),
    .gpio1_oe(pin_oe));

  acs_conv_model acs_conv_model_i (.clock(clock), .resetn(resetn), .start(start),
    .slot(slot), .main_running(main_adc_running), .done(conv_done), .data(conv_data),
    .target(strobe));

  // Clock, cycle count and event recorders
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (start) n_starts = n_starts + 1;
    if (start && slot == 4'h6) gpio_seq = {gpio_seq[20:0], gsel};
    if (start && slot == 4'h5) cell_last = csel;
    if (cs_done) begin cs_t0 = cs_t1; cs_t1 = cyc; cs_n = cs_n + 1; end
  end

  task tick(input integer n);
    begin repeat (n) @(posedge clock); #1; end
  endtask

  task go(input [1:0] m, input [4:0] c, input [3:0] g);
    begin
      aux_run_mode_field = m; aux_cell_channel_select = c; aux_gpio_channel_select = g;
      aux_go_write = 1'b1; n_starts = 0; tick(1); aux_go_write = 1'b0;
    end
  endtask

  task wait_idle;
    begin
      for (i = 0; i < 20000 && run; i = i + 1) tick(1);
      `CHK(run, 1'b0, "run did not end")
    end
  endtask

  task wrap_up;
    begin
      if (fail_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask

  // Watchdog against a hung sequence
  initial begin #400000; fail_count = fail_count + 1; wrap_up; end

  // Main sequence
  initial
  begin
    tick(20); resetn = 1'b1; tick(1);
    `CHK(cell_res, 16'h8000, "cell result reset")
    `CHK({readback, run, pin, pin_oe}, 4'b0010, "reset outputs")
    go(2'h1, 5'h00, 4'h0); aux_run_mode_field = 2'h2; wait_idle;
    `CHK(n_starts, 15, "single run length")
    `CHK({misc_rdy, gpio_rdy, cell_res}, {2'b10, 16'h8000}, "single run flags")
    aux_filter_settle_select = 2'h0; go(2'h3, 5'h00, 4'h0); wait_idle;
    `CHK(n_starts, 120, "eight run length")
    `CHK(gpio_seq, 24'h0A62EF, "gpio visit order")
    `CHK({gpio_rdy, cell_rdy}, 2'b11, "gpio and cell ready")
    main_adc_running = 1'b1; gpio_function_config = 8'h04; aux_filter_settle_select = 2'h1;
    go(2'h1, 5'h04, 4'h3); wait_idle; main_adc_running = 1'b0;
    `CHK({cell_rdy, cell_res, gpio_res}, {1'b1, 16'hA005, 16'hA006}, "locked results")
    `CHK(cell_last, 3'h3, "locked cell channel")
    go(2'h1, 5'h00, 4'h0);
    for (i = 0; i < 200 && n_starts < 5; i = i + 1) tick(1);
    sleep_mode = 1'b1; tick(1); k = n_starts; tick(100);
    `CHK({run, n_starts == k, k >= 5}, 3'b111, "sleep freeze")
    sleep_mode = 1'b0; wait_idle;
    `CHK(n_starts, 15, "resume after sleep")
    go(2'h2, 5'h00, 4'h0);
    for (i = 0; i < 2000 && n_starts < 40; i = i + 1) tick(1);
    `CHK({run, n_starts >= 40}, 2'b11, "continuous still running")
    go(2'h0, 5'h00, 4'h0); tick(5); k = n_starts; tick(60);
    `CHK({run, n_starts == k}, 2'b01, "continuous stop")
    pin_en = 1'b1; tick(2);
    for (k = 0; k < 4; k = k + 1)
    begin
      p = (k == 0) ? `ACS_CS_CONV0_CYC : (k == 1) ? `ACS_CS_CONV1_CYC :
          (k == 2) ? `ACS_CS_CONV2_CYC : `ACS_CS_CONV3_CYC;
      dr = k[1:0]; main_adc_running = 1'b1; main_run_mode = 2'h1; main_go_pulse = 1'b1;
      tick(1); main_go_pulse = 1'b0; t0 = cyc; cs_n = 0;
      for (i = 0; i < 12000 && cs_n < 2; i = i + 1) tick(1);
      `CHK(cs_t1 - cs_t0, p / `ACS_CS_DIVIDER, "later conversion time")
      `CHK(cs_t0 - t0 > `ACS_CS_SETTLE_CYC + p - 5 && cs_t0 - t0 < `ACS_CS_SETTLE_CYC + p + 5,
        1'b1, "first conversion time")
      `CHK({pin, pin_oe, cs_run, cur}, {3'b011, 24'hF12345}, "result and pin low")
      rd_hi = 1'b1; tick(1); rd_hi = 1'b0;
      `CHK(pin, 1'b1, "pin high after read")
      if (k[0]) begin main_run_mode = 2'h0; main_go_pulse = 1'b1; tick(1); main_go_pulse = 1'b0; end
      main_adc_running = 1'b0; tick(2);
      `CHK(cs_run, 1'b0, "current converter stopped")
    end
    pin_en = 1'b0; tick(3);
    wrap_up;
  end
endmodule // acs_top_tb
